/* inc/vga_gsr_pkg.sv */
// Constants, port decode and types for the legacy general control and status bank
package vga_gsr_pkg;
   // Direct I/O port addresses (memory offsets are identical)
   localparam logic [15:0] ADDR_ST0_MISC = 16'h03c2;
   localparam logic [15:0] ADDR_ST1_MONO = 16'h03ba;
   localparam logic [15:0] ADDR_ST1_COLOR = 16'h03da;
   localparam logic [15:0] ADDR_FEAT_RD = 16'h03ca;
   localparam logic [15:0] ADDR_MISC_RD = 16'h03cc;
   localparam logic [7:0] ADDR_LEGACY_HI = 8'h03;
   // Field positions and masks
   localparam int ST0_IRQ_BIT = 7;
   localparam int ST0_SENSE_BIT = 4;
   localparam int ST1_VRET_BIT = 3;
   localparam int ST1_DE_BIT = 0;
   localparam int MISC_EMUL_BIT = 0;
   localparam logic [7:0] MISC_MASK = 8'hef;
   localparam logic [7:0] FEAT_MASK = 8'h08;
   // Values after reset
   localparam logic [7:0] MISC_RST = 8'h00;
   localparam logic [7:0] FEAT_RST = 8'h00;
   // Synchroniser vector: palette bits, pipe v/vb/hb, vga v/vb/hb
   localparam int SYNC_W = 14;
   localparam logic [SYNC_W-1:0] SYNC_RST = 14'h0000;

   typedef enum logic [2:0] {
      PORT_NONE = 3'b000,
      PORT_ST0_MISC = 3'b001,
      PORT_ST1_FEAT = 3'b010,
      PORT_FEAT_RD = 3'b011,
      PORT_MISC_RD = 3'b100
   } port_e;

   // Direct decode of one byte lane, no index involved
   function automatic port_e decode_port(input logic [15:0] a, input logic color, input logic wr);
      port_e p;
      p = PORT_NONE;
      if (a == ADDR_ST0_MISC) begin
         p = PORT_ST0_MISC;
      end else if (a == (color ? ADDR_ST1_COLOR : ADDR_ST1_MONO)) begin
         p = PORT_ST1_FEAT;
      end else if (!wr && a == ADDR_FEAT_RD) begin
         p = PORT_FEAT_RD;
      end else if (!wr && a == ADDR_MISC_RD) begin
         p = PORT_MISC_RD;
      end
      return p;
   endfunction
endpackage

/* inc/status_if.sv */
// Live retrace, blanking and feedback status between selector and register bank
`timescale 1ns/1ps
interface status_if;
   logic vret;
   logic blank;
   logic [1:0] fbk;
   modport src (output vret, output blank, output fbk);
   modport dst (input vret, input blank, input fbk);
endinterface

/* verilog/status_sync.sv */
// Two-stage synchroniser for the raw timing and palette status vector
`timescale 1ns/1ps
module status_sync
   import vga_gsr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Raw and synchronised status
   input wire logic [SYNC_W-1:0] raw,
   output logic [SYNC_W-1:0] synced
);
   logic [SYNC_W-1:0] meta_q;
   logic [SYNC_W-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         meta_q <= SYNC_RST;
         sync_q <= SYNC_RST;
      end else begin
         meta_q <= raw;
         sync_q <= meta_q;
      end
   end

   assign synced = sync_q;
endmodule

/* verilog/status_select.sv */
// Picks the timing source and the palette feedback pair for input status one
`timescale 1ns/1ps
module status_select
   import vga_gsr_pkg::*;
(
   // Synchronised status and selection
   input wire logic [SYNC_W-1:0] synced,
   input wire logic vga_disable,
   input wire logic [1:0] plane_sel,
   // Selected status
   status_if.src st
);
   logic [7:0] pal;

   assign pal = synced[13:6];

   // Pixel-generation timing, or the assigned pipe while VGA is off
   always_comb begin
      if (vga_disable) begin
         st.vret = synced[5];
         st.blank = synced[4] | synced[3];
      end else begin
         st.vret = synced[2];
         st.blank = synced[1] | synced[0];
      end
   end

   // Feedback pair follows the colour plane select
   always_comb begin
      case (plane_sel)
         2'b00: st.fbk = {pal[2], pal[0]};
         2'b01: st.fbk = {pal[5], pal[4]};
         2'b10: st.fbk = {pal[3], pal[1]};
         2'b11: st.fbk = {pal[7], pal[6]};
         default: st.fbk = 2'b00;
      endcase
   end
endmodule

/* verilog/vga_general_status_regs.sv */
// Legacy VGA general control and status register bank on the host I/O path
`timescale 1ns/1ps
module vga_general_status_regs
   import vga_gsr_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // Host I/O cycle from the bridge
   input wire logic [15:0] io_addr,
   input wire logic io_word,
   input wire logic io_rd,
   input wire logic io_wr,
   input wire logic [15:0] io_wdata,
   output logic io_claim,
   output logic [15:0] io_rdata,
   output logic io_rvalid,
   // Timing from VGA pixel generation
   input wire logic vga_hblank,
   input wire logic vga_vblank,
   input wire logic vga_vsync,
   // Timing from the pipe VGA is assigned to
   input wire logic pipe_hblank,
   input wire logic pipe_vblank,
   input wire logic pipe_vsync,
   // Display configuration
   input wire logic vga_disable,
   input wire logic [7:0] palette_color,
   input wire logic [1:0] plane_sel,
   // Register contents to the rest of the display
   output logic [7:0] misc_output,
   output logic [7:0] feature_control,
   output logic emul_color
);
   logic lane_ok;
   logic [15:0] addr_hi;
   port_e p0;
   port_e p1;
   logic hit0;
   logic hit1;
   logic [7:0] misc_q;
   logic [7:0] feat_q;
   logic [15:0] rdata_q;
   logic rvalid_q;
   logic [SYNC_W-1:0] raw_vec;
   logic [SYNC_W-1:0] synced_vec;

   status_if st_if();

   // Live status crosses into the register clock before use
   assign raw_vec = {palette_color, pipe_vsync, pipe_vblank, pipe_hblank,
                     vga_vsync, vga_vblank, vga_hblank};

   status_sync u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .raw(raw_vec),
      .synced(synced_vec)
   );

   // Source choice by VGA disable; fitted modes just pass pipe timing on
   status_select u_select (
      .synced(synced_vec),
      .vga_disable(vga_disable),
      .plane_sel(plane_sel),
      .st(st_if.src)
   );

   // Lane decode; an odd word address is not ours to answer
   assign lane_ok = !(io_word && io_addr[0]);
   assign addr_hi = io_addr + 16'h0001;

   // Both lanes use the same direct decode, selected by the emulation bit
   always_comb begin
      p0 = decode_port(io_addr, misc_q[MISC_EMUL_BIT], io_wr);
      p1 = PORT_NONE;
      if (io_word) begin
         p1 = decode_port(addr_hi, misc_q[MISC_EMUL_BIT], io_wr);
      end
   end

   assign hit0 = lane_ok && (p0 != PORT_NONE);
   assign hit1 = lane_ok && (p1 != PORT_NONE);

   // Only the legacy ports are ever claimed
   assign io_claim = (io_rd || io_wr) && (hit0 || hit1);

   // Miscellaneous output, written at the shared status port
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         misc_q <= MISC_RST;
      end else if (io_wr && hit0 && p0 == PORT_ST0_MISC) begin
         misc_q <= io_wdata[7:0] & MISC_MASK;
      end else if (io_wr && hit1 && p1 == PORT_ST0_MISC) begin
         misc_q <= io_wdata[15:8] & MISC_MASK;
      end
   end

   // Feature control, written at the emulation-selected status one port
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         feat_q <= FEAT_RST;
      end else if (io_wr && hit0 && p0 == PORT_ST1_FEAT) begin
         feat_q <= io_wdata[7:0] & FEAT_MASK;
      end else if (io_wr && hit1 && p1 == PORT_ST1_FEAT) begin
         feat_q <= io_wdata[15:8] & FEAT_MASK;
      end
   end

   // Read value of one decoded port
   function automatic logic [7:0] rd_byte(input port_e p);
      logic [7:0] v;
      v = 8'h00;
      case (p)
         PORT_ST0_MISC: begin
            // No interrupt exists, so pending stays clear
            v[ST0_IRQ_BIT] = 1'b0;
            v[ST0_SENSE_BIT] = 1'b1;
         end
         PORT_ST1_FEAT: begin
            v[5:4] = st_if.fbk;
            v[ST1_VRET_BIT] = st_if.vret;
            v[ST1_DE_BIT] = st_if.blank;
         end
         PORT_FEAT_RD: begin
            v = feat_q;
         end
         PORT_MISC_RD: begin
            v = misc_q;
         end
         default: begin
            v = 8'h00;
         end
      endcase
      return v;
   endfunction

   // Read data is captured so the bridge sees a stable word
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_q <= 16'h0000;
      end else if (io_rd && io_claim) begin
         rdata_q <= {rd_byte(p1), rd_byte(p0)};
      end
   end

   // One-cycle answer marker for a claimed read
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= io_rd && io_claim;
      end
   end

   // Outputs
   assign io_rdata = rdata_q;
   assign io_rvalid = rvalid_q;
   assign misc_output = misc_q;
   assign feature_control = feat_q;
   assign emul_color = misc_q[MISC_EMUL_BIT];

   // Checks
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   sequence rd_st0_s;
      io_rd && !io_wr && lane_ok && p0 == PORT_ST0_MISC;
   endsequence

   sequence rd_st1_s;
      io_rd && !io_wr && lane_ok && p0 == PORT_ST1_FEAT;
   endsequence

   a_st0_irq_zero: assert property (
      rd_st0_s |=> io_rvalid && io_rdata[7] == 1'b0)
      else $error("Input status zero interrupt bit not zero");

   a_st0_sense_one: assert property (
      rd_st0_s |=> io_rdata[4] == 1'b1)
      else $error("Input status zero sense bit not one");

   a_st0_rsvd_zero: assert property (
      rd_st0_s |=> io_rdata[6:5] == 2'b00 && io_rdata[3:0] == 4'h0)
      else $error("Input status zero reserved bits not zero");

   a_st1_rsvd_zero: assert property (
      rd_st1_s |=> io_rdata[7:6] == 2'b00 && io_rdata[2:1] == 2'b00)
      else $error("Input status one reserved bits not zero");

   a_st1_vret_bit: assert property (
      rd_st1_s |=> io_rdata[3] == $past(st_if.vret))
      else $error("Vertical retrace bit does not follow status");

   a_st1_blank_bit: assert property (
      rd_st1_s |=> io_rdata[0] == $past(st_if.blank))
      else $error("Display enable bit does not follow blanking");

   a_st1_fbk_bits: assert property (
      rd_st1_s |=> io_rdata[5:4] == $past(st_if.fbk))
      else $error("Feedback bits do not follow palette pair");

   a_vga_vret_path: assert property (
      (!vga_disable && vga_vsync) [*3] |-> st_if.vret)
      else $error("Retrace does not follow pixel-generation sync");

   a_pipe_vret_path: assert property (
      (vga_disable && !pipe_vsync) [*3] |-> !st_if.vret)
      else $error("Retrace does not follow the assigned pipe");

   a_pipe_blank_live: assert property (
      (vga_disable && pipe_hblank) [*3] |-> st_if.blank)
      else $error("Blanking status not live from the pipe");

   a_st1_port_sel: assert property (
      (io_rd && !io_word && !emul_color && io_addr == ADDR_ST1_COLOR) |-> !io_claim)
      else $error("Colour status port claimed in mono emulation");

   a_color_port_sel: assert property (
      (io_rd && !io_word && emul_color && io_addr == ADDR_ST1_MONO) |-> !io_claim)
      else $error("Mono status port claimed in colour emulation");

   a_misc_write_back: assert property (
      (io_wr && !io_word && io_addr == ADDR_ST0_MISC) ##1 (io_rd && !io_wr && !io_word && io_addr == ADDR_MISC_RD)
      |=> io_rdata[7:0] == ($past(io_wdata[7:0], 2) & MISC_MASK))
      else $error("Misc output does not read back its write");

   a_feat_write_sel: assert property (
      (io_wr && !io_rd && !io_word && io_addr == (emul_color ? ADDR_ST1_COLOR : ADDR_ST1_MONO))
      |=> feature_control == ($past(io_wdata[7:0]) & FEAT_MASK))
      else $error("Feature control write at selected port lost");

   a_st0_no_write: assert property (
      (io_rd && !io_wr && !io_word && io_addr == ADDR_ST0_MISC) |=> $stable(misc_output))
      else $error("Read of shared status port changed misc output");

   a_legacy_only: assert property (
      io_claim |-> io_addr[15:8] == ADDR_LEGACY_HI)
      else $error("Port outside legacy range claimed");

   a_rvalid_pulse: assert property (
      (io_rd && io_claim) |=> io_rvalid ##1 !io_rvalid || $past(io_rd && io_claim))
      else $error("Read answer marker malformed");

   // Refusals, masks and answer timing
   a_odd_word_refused: assert property (
      (io_word && io_addr[0]) |-> !io_claim)
      else $error("Odd word access was claimed");

   a_ro_write_refused: assert property (
      (io_wr && !io_rd && !io_word && (io_addr == ADDR_FEAT_RD || io_addr == ADDR_MISC_RD)) |-> !io_claim)
      else $error("Write to a read-only port was claimed");

   a_misc_rsvd_clear: assert property (
      misc_output[4] == 1'b0)
      else $error("Misc output reserved bit set");

   a_feat_rsvd_clear: assert property (
      (feature_control & ~FEAT_MASK) == 8'h00)
      else $error("Feature control reserved bits set");

   a_rdata_hold: assert property (
      !(io_rd && io_claim) |=> $stable(io_rdata))
      else $error("Read data changed without a claimed read");

   a_rvalid_cause: assert property (
      io_rvalid |-> $past(io_rd && io_claim))
      else $error("Read answer without a claimed read");

   a_st0_high_lane: assert property (
      (io_rd && !io_wr && io_word && io_addr == ADDR_ST0_MISC) |=> io_rdata[15:8] == 8'h00)
      else $error("Unused high lane of a word read not zero");

   a_feat_read_back: assert property (
      (io_rd && !io_wr && !io_word && io_addr == ADDR_FEAT_RD) |=> io_rdata[7:0] == $past(feature_control))
      else $error("Feature control read port returns wrong value");

   a_st0_write_only_misc: assert property (
      (io_wr && !io_rd && !io_word && io_addr == ADDR_ST0_MISC) |=> $stable(feature_control))
      else $error("Misc write disturbed feature control");

   // Status path from each timing source, two cycles of synchroniser
   a_vga_hblank_path: assert property (
      (!vga_disable && vga_hblank) [*3] |-> st_if.blank)
      else $error("Horizontal blanking not shown as blanking");

   a_vga_vblank_path: assert property (
      (!vga_disable && vga_vblank) [*3] |-> st_if.blank)
      else $error("Vertical blanking not shown as blanking");

   a_vga_active_path: assert property (
      (!vga_disable && !vga_hblank && !vga_vblank && !vga_vsync) [*3] |-> !st_if.blank && !st_if.vret)
      else $error("Status not clear during active display");

   a_pipe_vblank_live: assert property (
      (vga_disable && pipe_vblank) [*3] |-> st_if.blank)
      else $error("Pipe vertical blanking not live");

   a_pipe_vret_live: assert property (
      (vga_disable && pipe_vsync) [*3] |-> st_if.vret)
      else $error("Pipe vertical retrace not live");

   // Main scenarios
   c_st1_in_retrace: cover property (
      rd_st1_s ##1 io_rdata[3]);

   c_pipe_status_read: cover property (
      vga_disable && io_rd && !io_wr && lane_ok && p0 == PORT_ST1_FEAT ##1 io_rdata[0]);

   c_misc_write: cover property (
      io_wr && io_claim && p0 == PORT_ST0_MISC);

   c_feat_color_write: cover property (
      io_wr && emul_color && io_claim && p0 == PORT_ST1_FEAT);

   c_misc_readback: cover property (
      io_wr && io_claim && p0 == PORT_ST0_MISC ##1 io_rd && io_claim && p0 == PORT_MISC_RD);
endmodule

/* bench/host_io_model.sv */
// Host I/O cycles arriving through the bus bridge
`timescale 1ns/1ps
module host_io_model (
   // Requests to the register bank
   output logic [15:0] io_addr,
   output logic io_word,
   output logic io_rd,
   output logic io_wr,
   output logic [15:0] io_wdata
);
   // Bus starts idle
   initial begin
      io_addr = 16'hffff;
      io_word = 1'b0;
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_wdata = 16'hffff;
   end

   // Byte or 16-bit cycles only, never wider
   // Words use even addresses, odd only when a refusal is wanted
   task automatic req(input logic rd, input logic wr, input logic [15:0] a, input logic w,
      input logic [15:0] wd);
      io_addr = a;
      io_word = w;
      io_rd = rd;
      io_wr = wr;
      io_wdata = wd;
   endtask

   // Released lines flip so a stale address never passes for a live one
   task automatic idle();
      io_rd = 1'b0;
      io_wr = 1'b0;
      io_addr = ~io_addr;
      io_wdata = ~io_wdata;
   endtask
endmodule

/* bench/vga_general_status_regs_tb.sv */
// Self-checking bench for the legacy general status register bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
   $display("CHECK FAILED %s exp=%h got=%h", nm, exp, got); end end
module vga_general_status_regs_tb;
   import vga_gsr_pkg::*;
   typedef struct {
      logic dis;
      logic hb;
      logic vb;
      logic vs;
      logic [7:0] pal;
      logic [1:0] psel;
      logic [15:0] addr;
      logic word;
      logic claim;
      logic [15:0] data;
   } row_s;
   logic core_clk, sys_rst, io_word, io_rd, io_wr, io_claim, io_rvalid, emul_color;
   logic [15:0] io_addr, io_wdata, io_rdata;
   logic vga_hblank, vga_vblank, vga_vsync, pipe_hblank, pipe_vblank, pipe_vsync, vga_disable;
   logic [7:0] palette_color, misc_output, feature_control;
   logic [1:0] plane_sel;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   // Reads under each status source, palette pair and port
   row_s rows [11] = '{
      '{0, 0, 0, 0, 8'h00, 2'h0, 16'h03c2, 0, 1, 16'h0010},
      '{0, 1, 0, 0, 8'h05, 2'h0, 16'h03ba, 0, 1, 16'h0031},
      '{0, 0, 1, 1, 8'h30, 2'h1, 16'h03ba, 0, 1, 16'h0039},
      '{0, 0, 0, 0, 8'h0a, 2'h2, 16'h03ba, 0, 1, 16'h0030},
      '{1, 1, 0, 1, 8'hc0, 2'h3, 16'h03ba, 0, 1, 16'h0039},
      '{1, 0, 1, 0, 8'h40, 2'h3, 16'h03ba, 0, 1, 16'h0011},
      '{0, 0, 0, 0, 8'h00, 2'h0, 16'h03da, 0, 0, 16'h0000},
      '{0, 0, 0, 0, 8'h00, 2'h0, 16'h03ca, 0, 1, 16'h0000},
      '{0, 0, 0, 0, 8'h00, 2'h0, 16'h03cc, 0, 1, 16'h0000},
      '{0, 0, 0, 0, 8'h00, 2'h0, 16'h03c2, 1, 1, 16'h0010},
      '{0, 0, 0, 0, 8'h00, 2'h0, 16'h03c3, 1, 0, 16'h0000}
   };

   vga_general_status_regs dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .io_addr(io_addr),
      .io_word(io_word), .io_rd(io_rd), .io_wr(io_wr), .io_wdata(io_wdata), .io_claim(io_claim),
      .io_rdata(io_rdata), .io_rvalid(io_rvalid), .vga_hblank(vga_hblank), .vga_vblank(vga_vblank),
      .vga_vsync(vga_vsync), .pipe_hblank(pipe_hblank), .pipe_vblank(pipe_vblank),
      .pipe_vsync(pipe_vsync), .vga_disable(vga_disable), .palette_color(palette_color),
      .plane_sel(plane_sel), .misc_output(misc_output), .feature_control(feature_control),
      .emul_color(emul_color));

   host_io_model host_u (.io_addr(io_addr), .io_word(io_word), .io_rd(io_rd), .io_wr(io_wr),
      .io_wdata(io_wdata));

   // Clock, 20 ns period
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // Hang guard, far above the expected hundred or so cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         results();
      end
   end

   task automatic results();
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic step();
      @(posedge core_clk);
      #1;
   endtask

   // The unused source carries the inverse so a wrong selection shows
   task automatic set_st(input logic dis, input logic hb, input logic vb, input logic vs,
      input logic [7:0] pal, input logic [1:0] ps);
      vga_disable = dis; // Other planes taken as off while VGA timing is used
      {vga_hblank, vga_vblank, vga_vsync} = dis ? ~{hb, vb, vs} : {hb, vb, vs};
      {pipe_hblank, pipe_vblank, pipe_vsync} = dis ? {hb, vb, vs} : ~{hb, vb, vs};
      palette_color = pal;
      plane_sel = ps;
      repeat (4) step(); // Covers the synchroniser delay
   endtask

   // One request; claim checked in its cycle, answer one cycle later
   task automatic access(input logic rd, input logic [15:0] a, input logic w, input logic [15:0] wd,
      input logic ec, input logic [15:0] ed);
      step();
      host_u.req(rd, !rd, a, w, wd);
      #2;
      `CHK("io_claim", ec, io_claim)
      step();
      if (rd) begin
         `CHK("io_rvalid", ec, io_rvalid)
         if (ec) `CHK("io_rdata", ed, io_rdata)
      end
      host_u.idle();
   endtask

   initial begin
      sys_rst = 1'b1;
      {vga_hblank, vga_vblank, vga_vsync, pipe_hblank, pipe_vblank, pipe_vsync} = 6'h00;
      vga_disable = 1'b0;
      palette_color = 8'h00;
      plane_sel = 2'h0;
      repeat (4) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      `CHK("reset", 34'h0, {misc_output, feature_control, emul_color, io_rvalid, io_rdata})
      foreach (rows[i]) begin
         set_st(rows[i].dis, rows[i].hb, rows[i].vb, rows[i].vs, rows[i].pal, rows[i].psel);
         access(1'b1, rows[i].addr, rows[i].word, 16'h0000, rows[i].claim, rows[i].data);
      end
      // Writes on read-only ports are not taken
      access(1'b0, 16'h03ca, 1'b0, 16'h00ff, 1'b0, 16'h0000);
      access(1'b0, 16'h03cc, 1'b0, 16'h00ff, 1'b0, 16'h0000);
      `CHK("feature_control", 8'h00, feature_control)
      // Feature write at the mono port, read back at its own port
      access(1'b0, 16'h03ba, 1'b0, 16'hffff, 1'b1, 16'h0000);
      `CHK("feature_control", 8'h08, feature_control)
      access(1'b1, 16'h03ca, 1'b0, 16'h0000, 1'b1, 16'h0008);
      // Misc write moves the status port to the colour group
      access(1'b0, 16'h03c2, 1'b0, 16'hffff, 1'b1, 16'h0000);
      `CHK("misc_output", 8'hef, misc_output)
      `CHK("emul_color", 1'b1, emul_color)
      access(1'b1, 16'h03cc, 1'b0, 16'h0000, 1'b1, 16'h00ef);
      access(1'b1, 16'h03ba, 1'b0, 16'h0000, 1'b0, 16'h0000);
      access(1'b0, 16'h03da, 1'b0, 16'h0000, 1'b1, 16'h0000);
      `CHK("feature_control", 8'h00, feature_control)
      set_st(1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 2'h0);
      access(1'b1, 16'h03da, 1'b0, 16'h0000, 1'b1, 16'h0001);
      // A change made in the same cycle as the read is still hidden by the synchroniser
      step();
      vga_hblank = 1'b0;
      host_u.req(1'b1, 1'b0, 16'h03da, 1'b0, 16'h0000);
      step();
      `CHK("sync_delay", 16'h0001, io_rdata)
      // Back to back: decode follows the new select on the very next cycle
      host_u.req(1'b0, 1'b1, 16'h03c2, 1'b0, 16'h0000);
      step();
      host_u.req(1'b1, 1'b0, 16'h03cc, 1'b0, 16'h0000);
      step();
      `CHK("b2b_misc", 16'h0000, io_rdata)
      host_u.req(1'b1, 1'b0, 16'h03ba, 1'b0, 16'h0000);
      #2;
      `CHK("b2b_claim", 1'b1, io_claim)
      step();
      `CHK("b2b_rvalid", 1'b1, io_rvalid)
      host_u.idle();
      // Reset in mid-run clears the written registers
      access(1'b0, 16'h03c2, 1'b0, 16'hffff, 1'b1, 16'h0000);
      step();
      sys_rst = 1'b1;
      repeat (3) step();
      sys_rst = 1'b0;
      `CHK("rerun", 17'h0, {misc_output, feature_control, emul_color})
      access(1'b1, 16'h03ba, 1'b0, 16'h0000, 1'b1, 16'h0000);
      results();
   end
endmodule
